// *** core/ciu_pkg.sv ***
// package: register map, field positions and timing of the cpu interrupt control unit
package ciu_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_CONTROL     = 4'h0;
   localparam logic [3:0] ADDR_PERIPH_EN1  = 4'h1;
   localparam logic [3:0] ADDR_PERIPH_FLG1 = 4'h2;
   localparam logic [3:0] ADDR_OPTION      = 4'h3;
   localparam logic [3:0] ADDR_SH_WORK     = 4'h4;
   localparam logic [3:0] ADDR_SH_STATUS   = 4'h5;
   localparam logic [3:0] ADDR_SH_BANK     = 4'h6;
   localparam logic [3:0] ADDR_SH_FSR0L    = 4'h7;
   localparam logic [3:0] ADDR_SH_FSR0H    = 4'h8;
   localparam logic [3:0] ADDR_SH_FSR1L    = 4'h9;
   localparam logic [3:0] ADDR_SH_FSR1H    = 4'hA;
   localparam logic [3:0] ADDR_SH_PC_LATCH_HIGH   = 4'hB;
   localparam logic [3:0] ADDR_CORE_STATE  = 4'hC;
   // data bank that holds the shadow copies
   localparam logic [4:0] SHADOW_BANK      = 5'h1F;
   // control register fields
   localparam int BIT_GIE  = 7;
   localparam int BIT_PERIPH_GROUP_ENABLE = 6;
   localparam int BIT_T0IE = 5;
   localparam int BIT_EXIE = 4;
   localparam int BIT_CDIE = 3;
   localparam int BIT_T0IF = 2;
   localparam int BIT_EXIF = 1;
   localparam int BIT_CDIF = 0;
   // option register: edge select position
   localparam int BIT_EDGE = 6;
   // status bits not saved: timeout and powerdown
   localparam logic [7:0] STATUS_KEEP_MASK = 8'hE7;
   localparam logic [7:0] RESET_BYTE       = 8'h00;
   // quarter phases per instruction cycle
   localparam int QPHASES = 4;
   localparam logic [14:0] VECTOR_ADDR = 15'h0004;

   typedef struct packed {
      logic [7:0] work;
      logic [7:0] status;
      logic [4:0] bank;
      logic [7:0] fsr0l;
      logic [7:0] fsr0h;
      logic [7:0] fsr1l;
      logic [7:0] fsr1h;
      logic [6:0] pc_latch_high;
   } ciu_ctx_t;

   typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_SLEEP, ST_WAKE} ciu_state_t;
endpackage

// *** core/ciu_top.sv ***
// cpu interrupt control unit: enables, flags, vectoring, shadow context, wake
`timescale 1ns/1ps
module ciu_top (
   input  wire logic             i_sys_clk,
   input  wire logic             i_sys_rst,
   // register port
   input  wire logic [3:0]       i_reg_addr,
   input  wire logic [7:0]       i_reg_wdata,
   input  wire logic             i_reg_wr,
   input  wire logic             i_reg_rd,
   output logic      [7:0]       o_reg_rdata,
   // core phase and sequencing
   input  wire logic             i_q1,
   input  wire logic             i_q4,
   input  wire logic             i_cycle_end,
   input  wire logic             i_sleep_instr,
   input  wire logic             i_return_from_irq_instr_instr,
   input  wire logic [14:0]      i_pc_return,
   input  wire ciu_pkg::ciu_ctx_t i_core_ctx,
   // event sources
   input  wire logic             i_ext_pin,
   input  wire logic             i_timer0_ovf,
   input  wire logic             i_per_pin_change_any,
   input  wire logic [7:0]       i_periph_flag_set,
   input  wire logic [7:0]       i_periph_flag_clr,
   input  wire logic [7:0]       i_clockless_mask,
   // to the core
   output logic                  o_irq_request,
   output logic                  o_flush,
   output logic                  o_push,
   output logic [14:0]           o_push_addr,
   output logic                  o_load_vector,
   output logic [14:0]           o_vector,
   output logic                  o_restore,
   output ciu_pkg::ciu_ctx_t     o_restore_ctx,
   output logic                  o_wake,
   output logic                  o_sleeping
);

   typedef struct packed {
      logic [7:0]          control;
      logic [7:0]          periph_en1;
      logic [7:0]          periph_flg1;
      logic                ext_edge_select;
      logic [2:0]          pin_sync;
      logic                pin_level;
      logic                ext_pending;
      ciu_pkg::ciu_ctx_t   shadow;
      ciu_pkg::ciu_state_t state;
      logic                wake_vector;
      logic [7:0]          rdata;
      logic                flush;
      logic                push;
      logic [14:0]         push_addr;
      logic                load_vector;
      logic                restore;
      logic                wake;
   } ciu_regs_t;

   ciu_regs_t r;
   ciu_regs_t next_r;
   logic      req;
   logic      wake_src;

   // request term shared by the run and sleep paths
   function automatic logic pending(input logic [7:0] ctl, input logic [7:0] pen,
                                    input logic [7:0] pfl);
      logic core_hit;
      logic per_hit;
      core_hit = (ctl[ciu_pkg::BIT_T0IE] & ctl[ciu_pkg::BIT_T0IF])
               | (ctl[ciu_pkg::BIT_EXIE] & ctl[ciu_pkg::BIT_EXIF])
               | (ctl[ciu_pkg::BIT_CDIE] & ctl[ciu_pkg::BIT_CDIF]);
      per_hit  = ctl[ciu_pkg::BIT_PERIPH_GROUP_ENABLE] & (|(pen & pfl));
      return core_hit | per_hit;
   endfunction

   assign req = r.control[ciu_pkg::BIT_GIE]
              & pending(r.control, r.periph_en1, r.periph_flg1);
   // peripheral sources wake only if marked clockless and enabled; enabled core sources wake without the mask
   assign wake_src = pending(r.control, r.periph_en1 & i_clockless_mask, r.periph_flg1);

   always_comb begin
      logic edge_hit;
      edge_hit = 1'b0;
      next_r = r;
      next_r.flush       = 1'b0;
      next_r.push        = 1'b0;
      next_r.load_vector = 1'b0;
      next_r.restore     = 1'b0;
      next_r.wake        = 1'b0;

      // pin passes three flops; a change counts when stages two and three agree
      next_r.pin_sync = {r.pin_sync[1:0], i_ext_pin};
      if (r.pin_sync[2] == r.pin_sync[1]) begin
         next_r.pin_level = r.pin_sync[2];
         // edge select picks rising or falling
         edge_hit = (r.pin_sync[2] != r.pin_level)
                  & (r.pin_sync[2] == r.ext_edge_select);
      end
      // edge latched any time, carried into the flag across Q4..Q1
      if (edge_hit) begin
         next_r.ext_pending = 1'b1;
      end

      // register writes first, hardware sets after so a set wins
      if (i_reg_wr) begin
         case (i_reg_addr)
            ciu_pkg::ADDR_CONTROL:    next_r.control[7:1] = i_reg_wdata[7:1];
            ciu_pkg::ADDR_PERIPH_EN1: next_r.periph_en1 = i_reg_wdata;
            ciu_pkg::ADDR_PERIPH_FLG1: next_r.periph_flg1 = i_reg_wdata;
            ciu_pkg::ADDR_OPTION:     next_r.ext_edge_select = i_reg_wdata[ciu_pkg::BIT_EDGE];
            ciu_pkg::ADDR_SH_WORK:    next_r.shadow.work = i_reg_wdata;
            ciu_pkg::ADDR_SH_STATUS:  next_r.shadow.status = i_reg_wdata & ciu_pkg::STATUS_KEEP_MASK;
            ciu_pkg::ADDR_SH_BANK:    next_r.shadow.bank = i_reg_wdata[4:0];
            ciu_pkg::ADDR_SH_FSR0L:   next_r.shadow.fsr0l = i_reg_wdata;
            ciu_pkg::ADDR_SH_FSR0H:   next_r.shadow.fsr0h = i_reg_wdata;
            ciu_pkg::ADDR_SH_FSR1L:   next_r.shadow.fsr1l = i_reg_wdata;
            ciu_pkg::ADDR_SH_FSR1H:   next_r.shadow.fsr1h = i_reg_wdata;
            ciu_pkg::ADDR_SH_PC_LATCH_HIGH:  next_r.shadow.pc_latch_high = i_reg_wdata[6:0];
            default:                  next_r.periph_en1 = r.periph_en1;
         endcase
      end

      if (i_timer0_ovf) begin
         next_r.control[ciu_pkg::BIT_T0IF] = 1'b1;
      end
      // external flag taken at Q1 only, valid edge sets it
      if (i_q1 && (r.ext_pending || edge_hit)) begin
         next_r.control[ciu_pkg::BIT_EXIF] = 1'b1;
         next_r.ext_pending = 1'b0;
      end
      // read-only summary follows the per-pin flags
      next_r.control[ciu_pkg::BIT_CDIF] = i_per_pin_change_any;
      next_r.periph_flg1 = (next_r.periph_flg1 & ~i_periph_flag_clr) | i_periph_flag_set;

      case (r.state)
         ciu_pkg::ST_RUN: begin
            if (i_cycle_end && i_return_from_irq_instr_instr) begin
               // pop, restore, global enable back on
               next_r.restore = 1'b1;
               next_r.control[ciu_pkg::BIT_GIE] = 1'b1;
            end else if (i_cycle_end && req) begin
               next_r.flush = 1'b1;
               next_r.push  = 1'b1;
               next_r.push_addr = i_pc_return;
               next_r.control[ciu_pkg::BIT_GIE] = 1'b0;
               // context to shadow, timeout and powerdown excluded
               next_r.shadow = i_core_ctx;
               next_r.shadow.status = i_core_ctx.status & ciu_pkg::STATUS_KEEP_MASK;
               next_r.state = ciu_pkg::ST_ENTRY;
            end else if (i_cycle_end && i_sleep_instr) begin
               next_r.state = ciu_pkg::ST_SLEEP;
            end
         end
         ciu_pkg::ST_ENTRY: begin
            // vector load one instruction cycle (four clocks) after the push
            if (i_cycle_end) begin
               next_r.load_vector = 1'b1;
               next_r.state = ciu_pkg::ST_RUN;
            end
         end
         ciu_pkg::ST_SLEEP: begin
            if (wake_src) begin
               next_r.wake = 1'b1;
               next_r.wake_vector = r.control[ciu_pkg::BIT_GIE];
               next_r.state = ciu_pkg::ST_WAKE;
            end
         end
         ciu_pkg::ST_WAKE: begin
            // following instruction runs before any branch
            if (i_cycle_end) begin
               next_r.state = ciu_pkg::ST_RUN;
            end
         end
         default: next_r.state = ciu_pkg::ST_RUN;
      endcase

      // read data stand one cycle after the strobe
      next_r.rdata = ciu_pkg::RESET_BYTE;
      if (i_reg_rd) begin
         case (i_reg_addr)
            ciu_pkg::ADDR_CONTROL:     next_r.rdata = r.control;
            ciu_pkg::ADDR_PERIPH_EN1:  next_r.rdata = r.periph_en1;
            ciu_pkg::ADDR_PERIPH_FLG1: next_r.rdata = r.periph_flg1;
            ciu_pkg::ADDR_OPTION:      next_r.rdata = {1'b0, r.ext_edge_select, 6'h00};
            ciu_pkg::ADDR_SH_WORK:     next_r.rdata = r.shadow.work;
            ciu_pkg::ADDR_SH_STATUS:   next_r.rdata = r.shadow.status;
            ciu_pkg::ADDR_SH_BANK:     next_r.rdata = {3'h0, r.shadow.bank};
            ciu_pkg::ADDR_SH_FSR0L:    next_r.rdata = r.shadow.fsr0l;
            ciu_pkg::ADDR_SH_FSR0H:    next_r.rdata = r.shadow.fsr0h;
            ciu_pkg::ADDR_SH_FSR1L:    next_r.rdata = r.shadow.fsr1l;
            ciu_pkg::ADDR_SH_FSR1H:    next_r.rdata = r.shadow.fsr1h;
            ciu_pkg::ADDR_SH_PC_LATCH_HIGH:   next_r.rdata = {1'b0, r.shadow.pc_latch_high};
            ciu_pkg::ADDR_CORE_STATE:  next_r.rdata = {5'h00, r.wake_vector, r.state};
            default:                   next_r.rdata = ciu_pkg::RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         r <= '0;
         r.state <= ciu_pkg::ST_RUN;
      end else begin
         r <= next_r;
      end
   end

   assign o_reg_rdata   = r.rdata;
   assign o_irq_request = req;
   assign o_flush       = r.flush;
   assign o_push        = r.push;
   assign o_push_addr   = r.push_addr;
   assign o_load_vector = r.load_vector;
   assign o_vector      = ciu_pkg::VECTOR_ADDR;
   // shadow contents, including software edits, go back to the core
   assign o_restore     = r.restore;
   assign o_restore_ctx = r.shadow;
   assign o_wake        = r.wake;
   assign o_sleeping    = (r.state == ciu_pkg::ST_SLEEP);

endmodule

// *** verification/ciu_checker.sv ***
// port checker for the cpu interrupt control unit
`timescale 1ns/1ps
module ciu_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   input wire logic [3:0]  i_reg_addr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic        i_reg_wr,
   input wire logic        i_cycle_end,
   input wire logic        i_return_from_irq_instr_instr,
   input wire logic [14:0] i_pc_return,
   input wire logic [14:0] o_push_addr,
   input wire logic        o_irq_request,
   input wire logic        o_flush,
   input wire logic        o_push,
   input wire logic        o_load_vector,
   input wire logic [14:0] o_vector,
   input wire logic        o_restore,
   input wire logic        o_wake,
   input wire logic        o_sleeping
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_vec; o_vector == 15'h0004; endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   property p_rst; $past(i_sys_rst) |-> !o_irq_request; endproperty
   a_rst: assert property (p_rst) else $error("request after reset");
   property p_flush; o_flush |-> o_push; endproperty
   a_flush: assert property (p_flush) else $error("flush without push");
   property p_cause; o_push |-> $past(o_irq_request) && $past(i_cycle_end); endproperty
   a_cause: assert property (p_cause) else $error("push without request");
   property p_load; o_push |-> ##[1:8] o_load_vector; endproperty
   a_load: assert property (p_load) else $error("vector late");
   property p_gie;
      i_reg_wr && i_reg_addr == ciu_pkg::ADDR_CONTROL && !i_reg_wdata[7] |=> !o_irq_request;
   endproperty
   a_gie: assert property (p_gie) else $error("request with global off");
   property p_clr; o_push |=> !o_irq_request; endproperty
   a_clr: assert property (p_clr) else $error("global not cleared");
   property p_ret; i_return_from_irq_instr_instr && i_cycle_end |-> ##[1:2] o_restore; endproperty
   a_ret: assert property (p_ret) else $error("no restore");
   property p_wake; o_wake |-> $past(o_sleeping); endproperty
   a_wake: assert property (p_wake) else $error("wake while awake");
   property p_paddr; o_push |-> o_push_addr == $past(i_pc_return); endproperty
   a_paddr: assert property (p_paddr) else $error("push address wrong");
   c_load: cover property (o_load_vector);
   c_ret: cover property (o_restore);
   c_wake: cover property (o_wake);
endmodule
bind ciu_top ciu_checker u_ciu_checker (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_cycle_end, .i_return_from_irq_instr_instr, .i_pc_return, .o_push_addr,
   .o_irq_request, .o_flush, .o_push,
   .o_load_vector, .o_vector, .o_restore, .o_wake, .o_sleeping);

// *** verification/ciu_core_model.sv ***
// core sequencer model: quarter phases, boundaries, program counter
`timescale 1ns/1ps
module ciu_core_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_load_vector,
   output logic             o_q1,
   output logic             o_q4,
   output logic             o_cycle_end,
   output logic [14:0]      o_pc
);
   logic [1:0] phase;
   assign o_q1 = (phase == 2'h0);
   assign o_q4 = (phase == 2'h3);
   assign o_cycle_end = o_q4;
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         phase <= 2'h0;
         o_pc <= 15'h0000;
      end else begin
         phase <= phase + 2'h1;
         if (i_load_vector) begin
            o_pc <= 15'h0004;
         end else if (o_cycle_end) begin
            o_pc <= o_pc + 15'h0001;
         end
      end
   end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the cpu interrupt control unit
`timescale 1ns/1ps
module testbench;
   localparam logic [3:0] CT = ciu_pkg::ADDR_CONTROL;
   localparam logic [3:0] PE = ciu_pkg::ADDR_PERIPH_EN1;
   logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_sleep_instr = 1'b0, i_return_from_irq_instr_instr = 1'b0, i_ext_pin = 1'b0;
   logic i_timer0_ovf = 1'b0, i_per_pin_change_any = 1'b0, i_q1, i_q4, i_cycle_end;
   logic [3:0] i_reg_addr = 4'h0;
   logic [7:0] i_reg_wdata = 8'h00, i_periph_flag_set = 8'h00, i_periph_flag_clr = 8'h00;
   logic [7:0] i_clockless_mask = 8'h00, o_reg_rdata, v;
   logic [14:0] i_pc_return, o_push_addr, o_vector;
   ciu_pkg::ciu_ctx_t i_core_ctx = '0, o_restore_ctx;
   logic o_irq_request, o_flush, o_push, o_load_vector, o_restore, o_wake, o_sleeping;
   int num_errors = 0, num_checks = 0, seed = 78, n, k;
   always #5 i_sys_clk = ~i_sys_clk;
   ciu_core_model u_ciu_core_model (.i_sys_clk, .i_sys_rst, .i_load_vector(o_load_vector),
      .o_q1(i_q1), .o_q4(i_q4), .o_cycle_end(i_cycle_end), .o_pc(i_pc_return));
   ciu_top u_ciu_top (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .i_q1, .i_q4, .i_cycle_end, .i_sleep_instr, .i_return_from_irq_instr_instr, .i_pc_return,
      .i_core_ctx, .i_ext_pin, .i_timer0_ovf, .i_per_pin_change_any, .i_periph_flag_set,
      .i_periph_flag_clr, .i_clockless_mask, .o_irq_request, .o_flush, .o_push, .o_push_addr,
      .o_load_vector, .o_vector, .o_restore, .o_restore_ctx, .o_wake, .o_sleeping);
   task automatic chk(input string s, input logic [14:0] seen, input logic [14:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", s, exp, seen);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge i_sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input string s, input logic [3:0] a, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1 chk(s, 15'(o_reg_rdata), 15'(e));
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      idle(20);
      i_sys_rst <= 1'b0;
      rdc("ctl", CT, 8'h00);
      rdc("pen", PE, 8'h00);
      v = 8'($random(seed));
      wr(PE, v);
      rdc("pen", PE, v);
      wr(PE, 8'h00);
      wr(CT, 8'h79);
      rdc("ctl", CT, 8'h78);
      wr(CT, 8'h00);
      i_timer0_ovf <= 1'b1;
      i_per_pin_change_any <= 1'b1;
      idle(1);
      i_timer0_ovf <= 1'b0;
      rdc("ctl", CT, 8'h05);
      i_per_pin_change_any <= 1'b0;
      rdc("ctl", CT, 8'h04);
      for (int e = 0; e < 2; e++) begin
         wr(ciu_pkg::ADDR_OPTION, 8'(e << 6));
         i_ext_pin <= e[0];
         idle(16);
         wr(CT, 8'h00);
         i_ext_pin <= !e[0];
         idle(16);
         rdc("ext", CT, 8'h00);
         i_ext_pin <= e[0];
         idle(16);
         rdc("ext", CT, 8'h02);
      end
      $display("flags done");
      wr(CT, 8'h00);
      i_core_ctx <= 60'({$random(seed), $random(seed)});
      wr(CT, 8'hA0);
      i_timer0_ovf <= 1'b1;
      idle(1);
      i_timer0_ovf <= 1'b0;
      for (n = 0; n < 40 && o_load_vector !== 1'b1; n++) @(negedge i_sys_clk);
      chk("lat", 15'(n <= 4 * ciu_pkg::QPHASES), 15'h0001);
      rdc("ctl", CT, 8'h24);
      rdc("shw", ciu_pkg::ADDR_SH_WORK, i_core_ctx.work);
      rdc("shs", ciu_pkg::ADDR_SH_STATUS, i_core_ctx.status & ciu_pkg::STATUS_KEEP_MASK);
      v = 8'($random(seed));
      wr(ciu_pkg::ADDR_SH_WORK, v);
      wr(CT, 8'h20);
      i_return_from_irq_instr_instr <= 1'b1;
      for (n = 0; n < 12 && o_restore !== 1'b1; n++) @(negedge i_sys_clk);
      chk("rst_w", 15'(o_restore_ctx.work), 15'(v));
      @(posedge i_sys_clk) i_return_from_irq_instr_instr <= 1'b0;
      rdc("ctl", CT, 8'hA0);
      $display("entry done");
      for (int i = 0; i < 3; i++) begin
         k = $random(seed) & 7;
         wr(CT, 8'h00);
         wr(PE, 8'(1 << k));
         wr(CT, 8'h80);
         i_periph_flag_set <= 8'(1 << k);
         idle(1);
         i_periph_flag_set <= 8'h00;
         @(negedge i_sys_clk) chk("req", 15'(o_irq_request), 15'h0000);
         rdc("pfl", ciu_pkg::ADDR_PERIPH_FLG1, 8'(1 << k));
         wr(CT, 8'hC0);
         @(negedge i_sys_clk) chk("req", 15'(o_irq_request), 15'h0001);
         wr(CT, 8'h00);
         // flag cleared before the next enable
         i_periph_flag_clr <= 8'(1 << k);
         idle(1);
         i_periph_flag_clr <= 8'h00;
         idle(12);
      end
      $display("group done");
      wr(PE, 8'h01);
      wr(CT, 8'h40);
      i_sleep_instr <= 1'b1;
      idle(4);
      i_sleep_instr <= 1'b0;
      i_periph_flag_set <= 8'h01;
      idle(1);
      i_periph_flag_set <= 8'h00;
      idle(12);
      @(negedge i_sys_clk) chk("slp", 15'(o_sleeping), 15'h0001);
      i_clockless_mask <= 8'h01;
      for (n = 0; n < 20 && o_wake !== 1'b1; n++) @(negedge i_sys_clk);
      chk("wake", 15'(n < 20), 15'h0001);
      for (k = 0; n < 40; n++) @(negedge i_sys_clk) k += int'(o_load_vector === 1'b1);
      chk("novec", 15'(k), 15'h0000);
      $display("sleep done");
      tally_and_finish();
   end
endmodule
